// *** verilog/isa_defs.svh ***
// Constants for the stop, arbitration and wake-up logic
// Assumes inclusion by bare name from the design files
`ifndef ISA_DEFS_SVH
`define ISA_DEFS_SVH
// Control register zero field positions
`define ISA_CR0_ARB_LOST_BIT 5
`define ISA_CR0_ARB_IE_BIT 4
`define ISA_CR0_WAKE_FLAG_BIT 1
`define ISA_CR0_WAKE_EN_BIT 0
// Reset values
`define ISA_FLAG_RST 1'b0
// Timing: line settle time before stop, in ns
`define ISA_SETTLE_NS 4700
`define ISA_CLK_NS 100
`define ISA_SETTLE_CYC ((`ISA_SETTLE_NS + `ISA_CLK_NS - 1) / `ISA_CLK_NS)
`endif

// *** verilog/isa_pkg.sv ***
// Types for the stop, arbitration and wake-up logic
// Assumes nothing of its surroundings
package isa_pkg;
  // Stop/restart sequencer states, one-hot
  typedef enum logic [4:0] {
    ISA_IDLE = 5'h01,
    ISA_P_LOW = 5'h02,
    ISA_P_SCLH = 5'h04,
    ISA_P_SDAH = 5'h08,
    ISA_RS_SDAH = 5'h10
  } isa_state_t;
  // Power modes of the host
  typedef enum logic [1:0] {
    ISA_PM_RUN = 2'h0,
    ISA_PM_SLEEP = 2'h1,
    ISA_PM_STOP = 2'h2,
    ISA_PM_WATCH = 2'h3
  } isa_pmode_t;
endpackage : isa_pkg

// *** verilog/isa_link_cond.sv ***
// Link-side bus condition detector on the serial clock domain
// Assumes link_clk is a sample clock from the link that runs while the bus lines change
`timescale 1ns/1ps
module isa_link_cond (
  // Link clock and reset
  input wire logic link_clk,
  input wire logic resetn,
  // Raw bus lines
  input wire logic scl_in,
  input wire logic sda_in,
  // Detected events as toggles
  output logic start_tgl_r,
  output logic stop_tgl_r
);
  logic [1:0] scl_sync_r, scl_sync_nxt;
  logic [1:0] sda_sync_r, sda_sync_nxt;
  logic sda_prev_r, sda_prev_nxt;
  logic start_tgl_nxt, stop_tgl_nxt;

  // ****************************************************
  // Condition detection
  // ****************************************************
  // Synchronise lines, then look for SDA edges while SCL high
  always_comb begin
    scl_sync_nxt = {scl_sync_r[0], scl_in};
    sda_sync_nxt = {sda_sync_r[0], sda_in};
    sda_prev_nxt = sda_sync_r[1];
    start_tgl_nxt = start_tgl_r;
    stop_tgl_nxt = stop_tgl_r;
    if (scl_sync_r[1] && sda_prev_r && !sda_sync_r[1]) begin
      start_tgl_nxt = !start_tgl_r;
    end
    if (scl_sync_r[1] && !sda_prev_r && sda_sync_r[1]) begin
      stop_tgl_nxt = !stop_tgl_r;
    end
  end

  // Register the detector state
  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
      sda_prev_r <= 1'b1;
      start_tgl_r <= 1'b0;
      stop_tgl_r <= 1'b0;
    end else begin
      scl_sync_r <= scl_sync_nxt;
      sda_sync_r <= sda_sync_nxt;
      sda_prev_r <= sda_prev_nxt;
      start_tgl_r <= start_tgl_nxt;
      stop_tgl_r <= stop_tgl_nxt;
    end
  end
endmodule : isa_link_cond

// *** verilog/isa_core.sv ***
// Stop generation, arbitration and wake-up of a two-wire bus master
// Assumes sys_clk at 10 MHz; bus lines are open drain, enable low
// Functional notes
// - Master ends transfer with SDA rising while SCL is high.
// - Master may repeat start without a stop in between.
// - Master select write 0 stops only if master, busy, done, no loss.
// - Arbitration compares SDA only while SCL high during own transfer.
// - Sent 1 seen low: stop driving data, set arbitration lost.
// - Arbitration interrupt only when its enable is 1.
// - Loss clears master select and direction; continue as slave.
// - Loss set with bus idle clears only by writing 0 to it.
// - Loss set with bus busy clears only by clearing transfer done.
// - Start on idle bus with a low line: loss without transfer done.
// - Disabled interface tracks no starts; bus busy stays 0. Code still sets wake flag on start in stop or watch.
// - Start while busy and lost sets transfer done with loss.
// - Wake-up works only when wake enable is written 1.
// - Start seen in stop or watch with enable sets wake flag.
// - Start wake-up acts only in stop and watch modes.
// - Loss bit5, enable bit4, wake flag bit1, wake enable bit0.
// - Master select 1 on occupied bus sets loss, no transfer.
`timescale 1ns/1ps
`include "isa_defs.svh"
module isa_core #(
  parameter int SETTLE_CYC = `ISA_SETTLE_CYC
) (
  // System clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Link clock
  input wire logic link_clk,
  // Bus lines
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_oe_n_r,
  output logic sda_oe_n_r,
  // Control from the rest of the unit
  input wire logic iface_enable,
  input wire isa_pkg::isa_pmode_t power_mode,
  input wire logic ms_wr_stb,
  input wire logic ms_wr_val,
  input wire logic rs_req_stb,
  input wire logic tx_bit_val,
  input wire logic tx_bit_drive,
  input wire logic done_set_stb,
  input wire logic done_clr_stb,
  input wire logic cr0_wr_stb,
  input wire logic [7:0] cr0_wr_data,
  // Status to the rest of the unit
  output logic [7:0] bus_control_zero_r,
  output logic master_select_r,
  output logic bus_busy_flag_r,
  output logic transmit_direction_flag_r,
  output logic done_r,
  output logic arb_irq_r,
  output logic wake_irq_r
);
  import isa_pkg::*;

  // Elaboration check: the settle counter needs at least one cycle
  if (SETTLE_CYC < 1) begin : g_bad_settle
    $error("SETTLE_CYC must be at least 1");
  end

  // ****************************************************
  // Link domain detector and crossing
  // ****************************************************
  logic start_tgl, stop_tgl;
  logic [2:0] st_sync_r, st_sync_nxt, sp_sync_r, sp_sync_nxt;
  logic [1:0] scl_s_r, sda_s_r;
  logic start_ev, stop_ev, scl_h, sda_h;

  isa_link_cond u_cond (
    .link_clk(link_clk),
    .resetn(resetn),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .start_tgl_r(start_tgl),
    .stop_tgl_r(stop_tgl)
  );

  // Toggle crossing of events; two-stage sync of line levels
  always_comb begin
    st_sync_nxt = {st_sync_r[1:0], start_tgl};
    sp_sync_nxt = {sp_sync_r[1:0], stop_tgl};
  end
  assign start_ev = st_sync_r[2] ^ st_sync_r[1];
  assign stop_ev = sp_sync_r[2] ^ sp_sync_r[1];
  assign scl_h = scl_s_r[1];
  assign sda_h = sda_s_r[1];

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_sync_r <= 3'h0;
      sp_sync_r <= 3'h0;
      scl_s_r <= 2'h3;
      sda_s_r <= 2'h3;
    end else begin
      st_sync_r <= st_sync_nxt;
      sp_sync_r <= sp_sync_nxt;
      scl_s_r <= {scl_s_r[0], scl_in};
      sda_s_r <= {sda_s_r[0], sda_in};
    end
  end

  // ****************************************************
  // Master, arbitration and flags
  // ****************************************************
  isa_state_t state_r, state_nxt;
  logic [$clog2(SETTLE_CYC+1)-1:0] cnt_r, cnt_nxt;
  logic ms_nxt, bb_nxt, trx_nxt, done_nxt;
  logic alf_r, alf_nxt, ale_r, ale_nxt;
  logic alf_busy_r, alf_busy_nxt;
  logic wuf_r, wuf_nxt, wue_r, wue_nxt;
  logic scl_oe_nxt, sda_oe_nxt;
  logic lost, stop_ok, start_ok;

  // Loss of arbitration while sending a 1 on SCL high
  assign lost = master_select_r && tx_bit_drive && tx_bit_val
    && scl_h && !sda_h && state_r == ISA_IDLE;
  assign stop_ok = master_select_r && bus_busy_flag_r && done_r
    && !alf_r;
  assign start_ok = !master_select_r && !bus_busy_flag_r && !done_r
    && !alf_r && scl_h && sda_h;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    ms_nxt = master_select_r;
    bb_nxt = bus_busy_flag_r;
    trx_nxt = transmit_direction_flag_r;
    done_nxt = done_r;
    alf_nxt = alf_r;
    alf_busy_nxt = alf_busy_r;
    ale_nxt = ale_r;
    wue_nxt = wue_r;
    wuf_nxt = wuf_r;
    scl_oe_nxt = scl_oe_n_r;
    sda_oe_nxt = sda_oe_n_r;
    // Bus busy tracking only while enabled
    if (!iface_enable) begin
      bb_nxt = 1'b0;
    end else if (start_ev) begin
      bb_nxt = 1'b1;
    end else if (stop_ev) begin
      bb_nxt = 1'b0;
    end
    // Software writes to control register zero
    if (cr0_wr_stb) begin
      ale_nxt = cr0_wr_data[`ISA_CR0_ARB_IE_BIT];
      wue_nxt = cr0_wr_data[`ISA_CR0_WAKE_EN_BIT];
      if (!cr0_wr_data[`ISA_CR0_WAKE_FLAG_BIT]) begin
        wuf_nxt = 1'b0;
      end
      if (!cr0_wr_data[`ISA_CR0_ARB_LOST_BIT] && !alf_busy_r) begin
        alf_nxt = 1'b0;
      end
    end
    // Transfer done set and clear
    if (done_clr_stb) begin
      done_nxt = 1'b0;
      if (alf_busy_r) begin
        alf_nxt = 1'b0;
      end
    end
    if (done_set_stb) begin
      done_nxt = 1'b1;
    end
    // Master select writes
    if (ms_wr_stb && ms_wr_val && !master_select_r) begin
      if (start_ok) begin
        ms_nxt = 1'b1;
        trx_nxt = 1'b1;
      end else if (bus_busy_flag_r) begin
        alf_nxt = 1'b1;
        alf_busy_nxt = 1'b1;
        done_nxt = 1'b1;
      end else if (!scl_h || !sda_h) begin
        alf_nxt = 1'b1;
        alf_busy_nxt = 1'b0;
      end
    end
    if (ms_wr_stb && !ms_wr_val && stop_ok && state_r == ISA_IDLE) begin
      ms_nxt = 1'b0;
      trx_nxt = 1'b0;
      state_nxt = ISA_P_LOW;
      cnt_nxt = '0;
    end
    // Repeated start while holding the bus
    if (rs_req_stb && stop_ok && state_r == ISA_IDLE) begin
      state_nxt = ISA_RS_SDAH;
      cnt_nxt = '0;
    end
    // Arbitration loss
    if (lost) begin
      alf_nxt = 1'b1;
      alf_busy_nxt = bus_busy_flag_r;
      ms_nxt = 1'b0;
      trx_nxt = 1'b0;
      sda_oe_nxt = 1'b1;
    end else if (state_r == ISA_IDLE) begin
      sda_oe_nxt = !(master_select_r && tx_bit_drive && !tx_bit_val);
    end
    // Stop and repeated start sequencer
    case (state_r)
      ISA_IDLE: begin
        scl_oe_nxt = 1'b1;
      end
      ISA_P_LOW: begin
        sda_oe_nxt = 1'b0;
        scl_oe_nxt = 1'b0;
        cnt_nxt = cnt_r + 1'b1;
        if (int'(cnt_r) >= SETTLE_CYC - 1) begin
          state_nxt = ISA_P_SCLH;
          cnt_nxt = '0;
        end
      end
      ISA_P_SCLH: begin
        scl_oe_nxt = 1'b1;
        cnt_nxt = cnt_r + 1'b1;
        if (int'(cnt_r) >= SETTLE_CYC - 1 && scl_h) begin
          state_nxt = ISA_P_SDAH;
          cnt_nxt = '0;
        end
      end
      ISA_P_SDAH: begin
        sda_oe_nxt = 1'b1;
        state_nxt = ISA_IDLE;
      end
      ISA_RS_SDAH: begin
        sda_oe_nxt = 1'b1;
        scl_oe_nxt = 1'b1;
        cnt_nxt = cnt_r + 1'b1;
        if (int'(cnt_r) >= SETTLE_CYC - 1 && scl_h) begin
          sda_oe_nxt = 1'b0;
          state_nxt = ISA_IDLE;
        end
      end
      default: begin
        state_nxt = ISA_IDLE;
      end
    endcase
    // Wake-up on start in stop or watch mode
    if (wue_r && start_ev && (power_mode == ISA_PM_STOP
        || power_mode == ISA_PM_WATCH)) begin
      wuf_nxt = 1'b1;
    end
  end

  // Register control state and outputs
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= ISA_IDLE;
      cnt_r <= '0;
      master_select_r <= 1'b0;
      bus_busy_flag_r <= 1'b0;
      transmit_direction_flag_r <= 1'b0;
      done_r <= 1'b0;
      alf_r <= `ISA_FLAG_RST;
      alf_busy_r <= 1'b0;
      ale_r <= `ISA_FLAG_RST;
      wuf_r <= `ISA_FLAG_RST;
      wue_r <= `ISA_FLAG_RST;
      scl_oe_n_r <= 1'b1;
      sda_oe_n_r <= 1'b1;
      bus_control_zero_r <= 8'h00;
      arb_irq_r <= 1'b0;
      wake_irq_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      master_select_r <= ms_nxt;
      bus_busy_flag_r <= bb_nxt;
      transmit_direction_flag_r <= trx_nxt;
      done_r <= done_nxt;
      alf_r <= alf_nxt;
      alf_busy_r <= alf_busy_nxt;
      ale_r <= ale_nxt;
      wuf_r <= wuf_nxt;
      wue_r <= wue_nxt;
      scl_oe_n_r <= scl_oe_nxt;
      sda_oe_n_r <= sda_oe_nxt;
      bus_control_zero_r <= {2'h0, alf_nxt, ale_nxt, 2'h0, wuf_nxt,
        wue_nxt};
      arb_irq_r <= alf_nxt && ale_nxt;
      wake_irq_r <= wuf_nxt && wue_nxt;
    end
  end
endmodule : isa_core

// *** tb/isa_peer.sv ***
// Peer master model on the shared two-wire bus
// Assumes the bench ANDs its drives into pulled-up lines
`timescale 1ns/1ps
module isa_peer (
  // Link clock made by the peer
  output logic link_clk,
  // Open-drain drives, 0 pulls low
  output logic scl_drv,
  output logic sda_drv
);
  logic run;
  // Idle bus, clock runs through reset then parks
  initial begin
    link_clk = 1'b0;
    scl_drv = 1'b1;
    sda_drv = 1'b1;
    run = 1'b1;
    #1230 run = 1'b0;
  end
  // Link clock toggles through reset and inside frames
  always #40 if (run) link_clk = ~link_clk;
  // Data falls while clock high
  task automatic send_start();
    run = 1'b1;
    #400 sda_drv = 1'b0;
    #400 scl_drv = 1'b0;
  endtask : send_start
  // Data rises while clock high, bus free
  task automatic send_stop();
    #400 scl_drv = 1'b1;
    #400 sda_drv = 1'b1;
    #400 run = 1'b0;
  endtask : send_stop
endmodule : isa_peer

// *** tb/isa_assertions.sv ***
// Checker for stop, arbitration and wake-up relations
// Assumes binding to isa_core, sys_clk domain only
`timescale 1ns/1ps
module isa_chk (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Controls
  input wire logic iface_enable,
  input wire isa_pkg::isa_pmode_t power_mode,
  input wire logic ms_wr_stb,
  input wire logic ms_wr_val,
  input wire logic cr0_wr_stb,
  input wire logic done_clr_stb,
  // Status
  input wire logic [7:0] bus_control_zero_r,
  input wire logic master_select_r,
  input wire logic bus_busy_flag_r,
  input wire logic transmit_direction_flag_r,
  input wire logic done_r,
  input wire logic arb_irq_r,
  input wire logic wake_irq_r
);
  import isa_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // Field aliases
  wire logic loss = bus_control_zero_r[5];
  wire logic wf = bus_control_zero_r[1];
  wire logic we = bus_control_zero_r[0];
  // Start request on an occupied bus
  sequence s_busy_req;
    ms_wr_stb && ms_wr_val && !master_select_r && !loss && bus_busy_flag_r;
  endsequence
  property p_arb_irq;
    arb_irq_r == (loss && bus_control_zero_r[4]);
  endproperty
  a_arb_irq: assert property (p_arb_irq) else $error("loss irq");
  property p_wake_irq;
    wake_irq_r == (wf && we);
  endproperty
  a_wake_irq: assert property (p_wake_irq) else $error("wake irq");
  property p_slave;
    $rose(loss) |-> ##[0:1] (!master_select_r && !transmit_direction_flag_r);
  endproperty
  a_slave: assert property (p_slave) else $error("not slave");
  property p_idle_loss;
    $rose(loss) && !bus_busy_flag_r |-> !$rose(done_r);
  endproperty
  a_idle_loss: assert property (p_idle_loss) else $error("done set");
  property p_loss_clr;
    $fell(loss) |-> $past(cr0_wr_stb) || $past(done_clr_stb);
  endproperty
  a_loss_clr: assert property (p_loss_clr) else $error("loss cleared");
  property p_wake_mode;
    $rose(wf) |-> $past(we) && $past(power_mode) inside {ISA_PM_STOP,
      ISA_PM_WATCH};
  endproperty
  a_wake_mode: assert property (p_wake_mode) else $error("wake mode");
  property p_stop_ok;
    $fell(master_select_r) && !loss |->
      $past(ms_wr_stb && !ms_wr_val && bus_busy_flag_r && done_r);
  endproperty
  a_stop_ok: assert property (p_stop_ok) else $error("bad stop");
  property p_off_idle;
    !iface_enable |=> !bus_busy_flag_r;
  endproperty
  a_off_idle: assert property (p_off_idle) else $error("busy off");
  property p_busy_loss;
    s_busy_req |=> loss && done_r;
  endproperty
  a_busy_loss: assert property (p_busy_loss) else $error("no done");
endmodule : isa_chk
bind isa_core isa_chk chk (.sys_clk, .resetn, .iface_enable, .power_mode,
  .ms_wr_stb, .ms_wr_val, .cr0_wr_stb, .done_clr_stb, .bus_control_zero_r,
  .master_select_r, .bus_busy_flag_r, .transmit_direction_flag_r, .done_r,
  .arb_irq_r, .wake_irq_r);

// *** tb/tb.sv ***
// Bench for the stop, arbitration and wake-up core
// Assumes isa_peer as the other master on the bus
`timescale 1ns/1ps
module tb;
  import isa_pkg::*;
  logic sys_clk, resetn, link_clk, scl_in, sda_in, scl_oe_n_r, sda_oe_n_r;
  logic iface_enable, ms_wr_stb, ms_wr_val, rs_req_stb, tx_bit_val;
  logic tx_bit_drive, done_set_stb, done_clr_stb, cr0_wr_stb, low_sda;
  logic [7:0] cr0_wr_data, bus_control_zero_r;
  logic master_select_r, bus_busy_flag_r, transmit_direction_flag_r;
  logic done_r, arb_irq_r, wake_irq_r, scl_drv, sda_drv;
  isa_pmode_t power_mode;
  int error_cnt = 0, compares = 0;
  int m_bb, m_done, m_loss, m_lbusy, m_ale, m_wf, m_we;
  isa_core #(.SETTLE_CYC(2)) dut (.*);
  isa_peer peer (.link_clk, .scl_drv, .sda_drv);
  // Pulled-up open-drain lines
  assign scl_in = scl_drv & scl_oe_n_r;
  assign sda_in = sda_drv & sda_oe_n_r & ~low_sda;
  // System clock
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic summarize();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  // Watchdog
  initial begin
    #400000;
    error_cnt++;
    summarize();
  end
  // Compare ports with the model
  task automatic cmp();
    logic [10:0] g, e;
    repeat (4) @(posedge sys_clk);
    #1;
    g = {scl_oe_n_r, sda_oe_n_r, master_select_r, bus_busy_flag_r, done_r,
      bus_control_zero_r[5:4], bus_control_zero_r[1:0], arb_irq_r, wake_irq_r};
    e = {3'h6, m_bb[0], m_done[0], m_loss[0], m_ale[0], m_wf[0], m_we[0],
      m_loss[0] & m_ale[0], m_wf[0] & m_we[0]};
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch t=%0t got %0h exp %0h", $time, g, e);
    end
  endtask : cmp
  task automatic wr_cr0(input logic [7:0] d);
    @(posedge sys_clk);
    cr0_wr_stb <= 1'b1;
    cr0_wr_data <= d;
    @(posedge sys_clk);
    cr0_wr_stb <= 1'b0;
    m_ale = d[4];
    m_we = d[0];
    m_wf = m_wf & d[1];
    if (!d[5] && !m_lbusy) m_loss = 0;
  endtask : wr_cr0
  task automatic wr_ms();
    @(posedge sys_clk);
    ms_wr_stb <= 1'b1;
    @(posedge sys_clk);
    ms_wr_stb <= 1'b0;
    if (m_bb || !sda_in || !scl_in) begin
      m_done = m_bb;
      m_lbusy = m_bb;
      m_loss = 1;
    end
  endtask : wr_ms
  task automatic clr_done();
    @(posedge sys_clk);
    done_clr_stb <= 1'b1;
    @(posedge sys_clk);
    done_clr_stb <= 1'b0;
    m_done = 0;
    if (m_lbusy) m_loss = 0;
    m_lbusy = 0;
  endtask : clr_done
  task automatic frame_start();
    peer.send_start();
    m_bb = iface_enable;
    // Let the start event cross both synchronisers
    repeat (4) @(posedge sys_clk);
    if (m_we && power_mode inside {ISA_PM_STOP, ISA_PM_WATCH}) m_wf = 1;
  endtask : frame_start
  task automatic frame_stop();
    peer.send_stop();
    m_bb = 0;
  endtask : frame_stop
  // Main sequence
  initial begin
    {m_bb, m_done, m_loss, m_lbusy, m_ale, m_wf, m_we} = '0;
    {resetn, ms_wr_stb, rs_req_stb, tx_bit_val, tx_bit_drive} = '0;
    {done_set_stb, done_clr_stb, cr0_wr_stb, low_sda, cr0_wr_data} = '0;
    iface_enable = 1'b1;
    ms_wr_val = 1'b1;
    power_mode = ISA_PM_RUN;
    void'($urandom(32'h5B2F));
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge sys_clk);
    cmp();
    for (int i = 0; i < 4; i++) begin
      wr_cr0(8'($urandom));
      cmp();
    end
    wr_cr0(8'h00);
    low_sda <= 1'b1;
    repeat (3) @(posedge sys_clk);
    wr_ms();
    cmp();
    wr_cr0(8'h30);
    cmp();
    clr_done();
    cmp();
    wr_cr0(8'h10);
    low_sda <= 1'b0;
    cmp();
    frame_start();
    cmp();
    wr_ms();
    cmp();
    wr_cr0(8'h00);
    cmp();
    clr_done();
    cmp();
    frame_stop();
    cmp();
    @(posedge sys_clk);
    iface_enable <= 1'b0;
    frame_start();
    @(posedge sys_clk);
    iface_enable <= 1'b1;
    wr_ms();
    cmp();
    frame_stop();
    wr_cr0(8'h00);
    for (int i = 0; i < 8; i++) begin
      @(posedge sys_clk);
      power_mode <= isa_pmode_t'(i[1:0]);
      wr_cr0({7'h00, i[2]});
      frame_start();
      cmp();
      frame_stop();
      wr_cr0(8'h00);
      cmp();
    end
    // Win the idle bus, then lose a sent 1 to a low data line
    tx_bit_drive <= 1'b1;
    tx_bit_val <= 1'b1;
    wr_ms();
    low_sda <= 1'b1;
    m_loss = 1;
    m_lbusy = 0;
    cmp();
    tx_bit_drive <= 1'b0;
    low_sda <= 1'b0;
    wr_cr0(8'h00);
    cmp();
    summarize();
  end
endmodule : tb
